// ==== core/dvr_pixel_formatter.v ====
/*
 * Pixel output formatter of a digital display receiver: takes decoded
 * pixels from the link side, buffers them and presents them on an even and
 * an odd pixel bus with a generated output pixel clock.
 * Assumes the link pins change on the falling link clock edge, so that a
 * 2-flop copy is steady at the synchronised rising edge, and an AXI4-Lite
 * master on clk.
 */
// Our own choices: the register offsets and register access over AXI4-Lite.
// Summary of operation
// [R1] Edge select picks output clock latching edge.
// [R2] Full power down floats outputs, ignores inputs.
// [R3] Full power down high means normal operation.
// [R4] Driver power down floats all but sync, control1.
// [R5] Driver power down high keeps drivers on.
// [R6] Two-pixel mode: even and odd together.
// [R7] One-pixel mode: sequential on even bus.
// [R8] Line starts with even pixel zero.
// [R9] Blue on even bus bits 0 to 7.
// [R10] Green on even bus bits 8 to 15.
// [R11] Two-pixel mode: even bus carries even only.
// [R12] Even bus changes with output pixel clock.
// [R13] One-pixel mode: odd bus held low.
// [R14] Red on even bus bits 16 to 23.
// [R15] Display enable high active, low blanking.
`include "dvr_defines.vh"

module dvr_pixel_formatter (
  input  wire        clk,
  input  wire        rst_n,
  // Link side: decoded pixel stream and its clock.
  input  wire        link_clk,
  input  wire [7:0]  link_blue,
  input  wire [7:0]  link_green,
  input  wire [7:0]  link_red,
  input  wire        link_de,
  input  wire        link_hsync,
  input  wire        link_vsync,
  input  wire [2:0]  link_ctl,
  // Power-down pins.
  input  wire        full_power_down_n,
  input  wire        output_driver_power_down_n,
  // Panel side.
  output reg         output_pixel_clock,
  output reg         output_pixel_clock_oe,
  output reg  [23:0] even_pixel_bus,
  output reg         even_pixel_bus_oe,
  output reg  [23:0] odd_pixel_bus,
  output reg         odd_pixel_bus_oe,
  output reg         display_enable_out,
  output reg         hsync_out,
  output reg         vsync_out,
  output reg         sync_oe,
  output reg         control_output_one,
  output reg         control_output_one_oe,
  output reg  [1:0]  control_out_hi,
  output reg         control_out_hi_oe,
  output reg         sync_detect_output,
  output reg         sync_detect_output_oe,
  // AXI4-Lite slave.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // Gather states, one-hot.
  localparam ST_EMPTY = 3'h1;  // Nothing staged.
  localparam ST_HALF  = 3'h2;  // Even pixel staged, odd awaited.
  localparam ST_FULL  = 3'h4;  // Ready for the next launch.

  // ----------------------------------------------------------------------
  // Pin synchronisers.
  // ----------------------------------------------------------------------
  localparam SW = 4 + `DVR_WORD_W - 1;
  reg [SW-1:0] pin_meta;  // First stage, read only by the second.
  reg [SW-1:0] pin_sync;  // Second stage, safe to use.
  reg          lclk_prev; // Synchronised link clock one cycle ago.

  // The data ride the same two stages as the clock so they stay aligned.
  always @(posedge clk) begin
    if (!rst_n) begin
      pin_meta  <= {SW{1'b0}};
      pin_sync  <= {SW{1'b0}};
      lclk_prev <= 1'b0;
    end else begin
      pin_meta  <= {full_power_down_n, output_driver_power_down_n,
                    link_clk, link_de, link_hsync, link_vsync, link_ctl,
                    link_red, link_green, link_blue};
      pin_sync  <= pin_meta;
      lclk_prev <= pin_sync[SW-3];
    end
  end

  wire        pd_full_n = pin_sync[SW-1];
  wire        pd_drv_n  = pin_sync[SW-2];
  wire        lclk_s    = pin_sync[SW-3];
  wire        lclk_rise = lclk_s && !lclk_prev;
  wire [29:0] in_word   = pin_sync[29:0];
  // [R2] [R3] power state
  wire        powered   = pd_full_n;

  // Configuration and status registers.
  reg  [1:0] cfg;          // Edge select and pixel width select.
  reg        overrun;      // A link pixel found the FIFO full.
  wire       edge_select = cfg[`DVR_CFG_EDGE];
  wire       width_two   = cfg[`DVR_CFG_WIDTH];
  wire [3:0] fifo_level;
  wire       fifo_in_ready;

  // ----------------------------------------------------------------------
  // Sync detect: link clock edges seen within the silence limit.
  // ----------------------------------------------------------------------
  reg [4:0] quiet_cnt;     // Cycles since the last link clock edge.
  always @(posedge clk) begin
    if (!rst_n || !powered) begin
      quiet_cnt <= 5'h00;
    end else if (lclk_rise) begin
      quiet_cnt <= 5'h00;
    end else if (quiet_cnt != 5'h1F) begin
      quiet_cnt <= quiet_cnt + 5'h01;
    end
  end
  reg  lclk_prev_seen;     // At least one edge seen since power-up.
  wire link_alive = (quiet_cnt < `DVR_SYNC_CYCLES) && lclk_prev_seen;
  always @(posedge clk) begin
    if (!rst_n || !powered) begin
      lclk_prev_seen <= 1'b0;
    end else if (lclk_rise) begin
      lclk_prev_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // FIFO on the pixel path.
  // ----------------------------------------------------------------------
  wire        head_valid;
  wire [29:0] head;
  reg         pop;
  // [R2] inputs ignored
  wire        push = lclk_rise && powered;

  dvr_fifo #(.WIDTH(`DVR_WORD_W), .DEPTH(`DVR_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (!powered),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (in_word),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head),
    .level     (fifo_level)
  );

  // ----------------------------------------------------------------------
  // Output clock divider and launch strobe.
  // ----------------------------------------------------------------------
  reg  [3:0] div_cnt;      // Position within the output clock period.
  wire [3:0] half = width_two ? `DVR_OCLK_HALF_2P : `DVR_OCLK_HALF_1P;
  wire       wrap = (div_cnt == half + half - 4'h1);
  wire [3:0] next_div = wrap ? 4'h0 : div_cnt + 4'h1;
  reg        launch;
  always @(posedge clk) begin
    if (!rst_n || !powered) begin
      div_cnt <= 4'h0;
    end else begin
      div_cnt <= wrap ? 4'h0 : div_cnt + 4'h1;
    end
  end
  // [R1] launch opposite edge
  always @* begin
    launch = 1'b0;
    if (edge_select) begin
      launch = (div_cnt == half - 4'h1);
    end else begin
      launch = wrap;
    end
  end

  // ----------------------------------------------------------------------
  // Gather: pair pixels for two-pixel mode.
  // ----------------------------------------------------------------------
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [29:0] slot_a;      // Even pixel (every pixel in one-pixel mode), or blanking word.
  reg  [29:0] slot_b;      // Odd pixel in two-pixel mode.
  reg         b_full;      // Slot B holds a pixel.
  reg         odd_next;    // Next active pixel of the line is odd.
  reg         load_a;
  reg         load_b;
  reg         zero_a;
  wire        head_de = head[29];

  always @* begin
    next_state = state;
    pop        = 1'b0;
    load_a     = 1'b0;
    load_b     = 1'b0;
    zero_a     = 1'b0;
    case (state)
      ST_EMPTY: begin
        if (head_valid) begin
          pop = 1'b1;
          if (width_two && head_de && odd_next) begin
            // [R11] stray odd pixel
            load_b     = 1'b1;
            zero_a     = 1'b1;
            next_state = ST_FULL;
          end else if (width_two && head_de) begin
            load_a     = 1'b1;
            next_state = ST_HALF;
          end else begin
            load_a     = 1'b1;
            next_state = ST_FULL;
          end
        end
      end
      ST_HALF: begin
        // [R6] pair even with odd
        if (head_valid && head_de) begin
          pop        = 1'b1;
          load_b     = 1'b1;
          next_state = ST_FULL;
        end else if (head_valid) begin
          next_state = ST_FULL;
        end
      end
      ST_FULL: begin
        if (launch) begin
          next_state = ST_EMPTY;
        end
      end
      default: begin
        next_state = ST_EMPTY;
      end
    endcase
  end

  // Staging registers follow the gather decisions.
  always @(posedge clk) begin
    if (!rst_n || !powered) begin
      state    <= ST_EMPTY;
      slot_a   <= 30'h0000_0000;
      slot_b   <= 30'h0000_0000;
      b_full   <= 1'b0;
      odd_next <= 1'b0;
    end else begin
      state <= next_state;
      if (load_a) begin
        slot_a <= head;
        b_full <= 1'b0;
      end else if (zero_a) begin
        slot_a <= {1'b1, head[28:24], 24'h00_0000};
      end
      if (load_b) begin
        slot_b <= head;
        b_full <= 1'b1;
      end
      // [R8] even pixel first
      if (pop) begin
        odd_next <= head_de ? !odd_next : 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output stage; power down clears all, else the pixel clock updates every cycle and the rest at launch.
  // ----------------------------------------------------------------------
  wire staged = (state == ST_FULL);
  always @(posedge clk) begin
    if (!rst_n || !powered) begin
      output_pixel_clock <= 1'b0;
      even_pixel_bus     <= 24'h00_0000;
      odd_pixel_bus      <= 24'h00_0000;
      display_enable_out <= 1'b0;
      hsync_out          <= 1'b0;
      vsync_out          <= 1'b0;
      control_output_one <= 1'b0;
      control_out_hi     <= 2'h0;
    end else begin
      output_pixel_clock <= (next_div < half);
      // [R12] change on launch
      if (launch && staged) begin
        // [R9] [R10] [R14] colour lanes
        even_pixel_bus     <= slot_a[23:0];
        // [R13] [R7] odd bus low
        odd_pixel_bus      <= (width_two && b_full) ? slot_b[23:0]
                                                    : 24'h00_0000;
        // [R15] active display flag
        display_enable_out <= slot_a[29];
        hsync_out          <= slot_a[28];
        vsync_out          <= slot_a[27];
        control_out_hi     <= slot_a[26:25];
        control_output_one <= slot_a[24];
      end else if (launch) begin
        // Underrun: blank the pixels and keep the syncs as they were.
        even_pixel_bus     <= 24'h00_0000;
        odd_pixel_bus      <= 24'h00_0000;
        display_enable_out <= 1'b0;
      end
    end
  end

  // Enables are registered so a pin never glitches while power state moves.
  always @(posedge clk) begin
    if (!rst_n) begin
      output_pixel_clock_oe <= 1'b0;
      even_pixel_bus_oe     <= 1'b0;
      odd_pixel_bus_oe      <= 1'b0;
      sync_oe               <= 1'b0;
      control_out_hi_oe     <= 1'b0;
      control_output_one_oe <= 1'b0;
      sync_detect_output_oe <= 1'b0;
      sync_detect_output    <= 1'b0;
    end else begin
      // [R4] [R5] driver power down
      output_pixel_clock_oe <= powered && pd_drv_n;
      even_pixel_bus_oe     <= powered && pd_drv_n;
      odd_pixel_bus_oe      <= powered && pd_drv_n;
      sync_oe               <= powered && pd_drv_n;
      control_out_hi_oe     <= powered && pd_drv_n;
      // [R2] all drivers off
      control_output_one_oe <= powered;
      sync_detect_output_oe <= powered;
      sync_detect_output    <= powered && link_alive;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite slave.
  // ----------------------------------------------------------------------
  reg        aw_held;      // Write address taken, waiting for data.
  reg [7:0]  aw_addr;
  reg        w_held;       // Write data taken, waiting for address.
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire clr_ovr  = do_write && (aw_addr == `DVR_REG_STATUS) && w_strb[0] &&
                  w_data[`DVR_ST_OVERRUN];

  // Write channels are taken independently; the write happens once both
  // halves are held, and the response follows.
  always @(posedge clk) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DVR_RESP_OKAY;
      cfg          <= `DVR_CFG_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `DVR_REG_CONFIG ||
                         aw_addr == `DVR_REG_STATUS) ? `DVR_RESP_OKAY
                                                     : `DVR_RESP_SLVERR;
        if (aw_addr == `DVR_REG_CONFIG && w_strb[0]) begin
          cfg <= w_data[1:0];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Overrun is sticky; a new overrun wins over a clear in the same cycle.
  always @(posedge clk) begin
    if (!rst_n) begin
      overrun <= 1'b0;
    end else if (push && !fifo_in_ready) begin
      overrun <= 1'b1;
    end else if (clr_ovr) begin
      overrun <= 1'b0;
    end
  end

  // Reads answer one cycle after the address is taken.
  always @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DVR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `DVR_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (s_axi_araddr == `DVR_REG_CONFIG) begin
        s_axi_rdata <= {30'h0000_0000, cfg};
      end else if (s_axi_araddr == `DVR_REG_STATUS) begin
        s_axi_rdata <= {24'h00_0000, fifo_level, link_alive, !pd_drv_n,
                        !pd_full_n, overrun};
      end else begin
        s_axi_rresp <= `DVR_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== core/dvr_defines.vh ====
/*
 * Constants of the pixel output formatter: register offsets, field
 * positions, reset values and timing counts.
 * Assumes it is included by bare name from every core file that needs it.
 */
`ifndef DVR_DEFINES_VH
`define DVR_DEFINES_VH

// ----------------------------------------------------------------------
// Register map (byte addresses), fields, reset values, AXI responses.
// ----------------------------------------------------------------------
`define DVR_REG_CONFIG     8'h00
`define DVR_REG_STATUS     8'h04
`define DVR_CFG_EDGE       0
`define DVR_CFG_WIDTH      1
`define DVR_CFG_RST        2'h1
`define DVR_ST_OVERRUN     0
`define DVR_RESP_OKAY      2'h0
`define DVR_RESP_SLVERR    2'h2

// ----------------------------------------------------------------------
// Timing counts and the FIFO word width and depth.
// ----------------------------------------------------------------------
`define DVR_CLK_NS         40
`define DVR_OCLK_HALF_1P   4'h4
`define DVR_OCLK_HALF_2P   4'h8
`define DVR_SYNC_LOSS_NS   1000
`define DVR_SYNC_CYCLES    ((`DVR_SYNC_LOSS_NS + `DVR_CLK_NS - 1) / `DVR_CLK_NS)
`define DVR_WORD_W         30
`define DVR_FIFO_DEPTH     8

`endif

// ==== core/dvr_fifo.v ====
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes a single clock and a synchronous active-low reset; flush empties
 * it in one cycle.
 */
module dvr_fifo #(
  parameter WIDTH = 30,
  parameter DEPTH = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [$clog2(DEPTH):0] level
);

  // ----------------------------------------------------------------------
  // Storage and pointers.
  // ----------------------------------------------------------------------
  localparam AW = $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];  // Word storage.
  reg [AW-1:0]    wr_ptr;           // Next slot to write.
  reg [AW-1:0]    rd_ptr;           // Oldest word.
  reg [AW:0]      count;            // Words held.

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  // Full and empty come straight from the count, so they are exact.
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign level     = count;

  // ----------------------------------------------------------------------
  // Pointer and count update.
  // ----------------------------------------------------------------------
  // Pointers wrap by modulo DEPTH, which needs DEPTH to be a power of two.
  always @(posedge clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // Memory write carries no reset; only written words are ever read.
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule

// ==== tb/dvr_pixel_properties.sv ====
/* Checker of the formatter's output pins and their enables.
 * Assumes it is bound to dvr_pixel_formatter and sees its ports only. */
module dvr_pixel_props (
  input wire        clk,
  input wire        rst_n,
  input wire        full_power_down_n,
  input wire        output_driver_power_down_n,
  input wire        output_pixel_clock,
  input wire        output_pixel_clock_oe,
  input wire [23:0] even_pixel_bus,
  input wire        even_pixel_bus_oe,
  input wire [23:0] odd_pixel_bus,
  input wire        odd_pixel_bus_oe,
  input wire        display_enable_out,
  input wire        sync_oe,
  input wire        control_output_one_oe,
  input wire        sync_detect_output_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Pins pass a synchroniser and a register, so they are held 5 cycles.
  sequence full_off;
    !full_power_down_n [*5];
  endsequence
  sequence drv_off;
    !output_driver_power_down_n [*5];
  endsequence
  // Enables that the driver power down must float.
  wire pix_oe = output_pixel_clock_oe | even_pixel_bus_oe |
                odd_pixel_bus_oe | sync_oe;
  // Outputs may only move where the output clock turns.
  property on_clock(logic oe, logic [23:0] v);
    oe && $past(oe) && $changed(v) |-> $changed(output_pixel_clock);
  endproperty
  AST_FULL_PD_FLOAT: assert property (
    full_off |-> !(pix_oe | control_output_one_oe | sync_detect_output_oe))
    else $error("output driven in full power down");
  AST_PD_CLEARS: assert property (
    full_off |-> even_pixel_bus == 24'h00_0000 && !display_enable_out)
    else $error("outputs not cleared in full power down");
  AST_DRV_PD_FLOAT: assert property (
    drv_off |-> !pix_oe)
    else $error("output driven in driver power down");
  AST_CONTROL_OUTPUT_ONE_KEEPS: assert property (
    (full_power_down_n && !output_driver_power_down_n) [*8]
    |-> control_output_one_oe && sync_detect_output_oe)
    else $error("control one or sync detect floated");
  AST_NORMAL_DRIVE: assert property (
    (full_power_down_n && output_driver_power_down_n) [*8] |->
    output_pixel_clock_oe && even_pixel_bus_oe && sync_oe)
    else $error("drivers off in normal operation");
  AST_BUS_ON_CLOCK: assert property (
    on_clock(even_pixel_bus_oe, even_pixel_bus))
    else $error("even bus moved off the output clock");
  AST_DE_ON_CLOCK: assert property (
    on_clock(sync_oe, {23'h00_0000, display_enable_out}))
    else $error("display enable moved off the output clock");
  AST_ODD_ON_CLOCK: assert property (
    on_clock(odd_pixel_bus_oe, odd_pixel_bus))
    else $error("odd bus moved off the output clock");
endmodule

bind dvr_pixel_formatter dvr_pixel_props i_dvr_pixel_props (.*);

// ==== tb/dvr_panel_model.sv ====
/* Panel-side model: latches the pixel buses on one output clock edge.
 * Assumes the bench tells it which edge the formatter is set to. */
module dvr_panel_model (
  input  wire         output_pixel_clock,
  input  wire         edge_sel,
  input  wire  [23:0] even_pixel_bus,
  input  wire  [23:0] odd_pixel_bus,
  input  wire         display_enable_out,
  output logic [23:0] cap_even,
  output logic [23:0] cap_odd,
  output logic        cap_de,
  output logic        cap_late,
  output int          cap_count
);
  timeunit 1ns;
  timeprecision 1ns;
  time t_chg = 0;
  time t_edge = 0;
  // Time of the last move of the launched data.
  always @(even_pixel_bus or odd_pixel_bus or display_enable_out)
    t_chg = $time;
  // latch edge
  // A real panel sees data that moves at its latch edge as a hazard.
  initial cap_count = 0;
  always @(output_pixel_clock) begin
    if (output_pixel_clock === edge_sel) begin
      t_edge = $time;
      #1;
      cap_late = (t_chg == t_edge);
      cap_even = even_pixel_bus;
      cap_odd = odd_pixel_bus;
      cap_de = display_enable_out;
      cap_count = cap_count + 1;
    end
  end
endmodule

// ==== tb/dvr_pixel_formatter_bench.sv ====
/* Self-checking bench of the pixel output formatter.
 * Assumes the design, the panel model and the bound checker. */
module dvr_pixel_formatter_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, link_clk, link_de, link_hsync, link_vsync;
  logic [7:0]  link_blue, link_green, link_red, s_axi_awaddr, s_axi_araddr;
  logic [2:0]  link_ctl;
  logic        full_power_down_n, output_driver_power_down_n;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, control_out_hi, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, output_pixel_clock;
  logic [23:0] even_pixel_bus, odd_pixel_bus, cap_even, cap_odd, want;
  logic        output_pixel_clock_oe, even_pixel_bus_oe, odd_pixel_bus_oe;
  logic        display_enable_out, hsync_out, vsync_out, sync_oe;
  logic        control_output_one, control_output_one_oe, control_out_hi_oe;
  logic        sync_detect_output, sync_detect_output_oe;
  logic        edge_sel, wide, cap_de, cap_late;
  int          cap_count;
  int          mismatches = 0;
  int          comparisons = 0;
  logic [23:0] exp_q [$];

  dvr_pixel_formatter i_dvr_pixel_formatter (.*);
  dvr_panel_model i_dvr_panel_model (.output_pixel_clock, .edge_sel,
    .even_pixel_bus, .odd_pixel_bus, .display_enable_out, .cap_even,
    .cap_odd, .cap_de, .cap_late, .cap_count);

  // The 25 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Cuts a hung run short; the tests need under a tenth of this.
  initial begin
    #2_000_000;
    mismatches++;
    print_verdict;
  end

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  // Bus lanes of a pixel: red high, green middle, blue low.
  function automatic logic [23:0] lanes(input logic [7:0] rd, gr, bl);
    return {rd, gr, bl};
  endfunction

  // One AXI4-Lite transfer; readies are seen settled before the edge.
  task automatic bus(input bit wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic [1:0] resp);
    logic ta, tw, tb;
    int n;
    n = 0;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    do begin
      @(negedge clk);
      ta = wr ? s_axi_awready : s_axi_arready;
      tw = wr & s_axi_wready;
      tb = wr ? s_axi_bvalid : s_axi_rvalid;
      rd = s_axi_rdata;
      resp = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      n++;
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end while (!tb && n < 200);
    if (!tb) check(32'h0000_0000, 32'h0000_0001);
    @(posedge clk);
  endtask

  // Two blanking words, n pixels and two more blanking words on the link, then the panel drains.
  task automatic send_line(input int n);
    logic [23:0] p;
    bit a;
    for (int i = -2; i < n + 2; i++) begin
      p = $urandom;
      a = (i >= 0 && i < n);
      link_de <= a;
      {link_red, link_green, link_blue} <= a ? p : 24'h00_0000;
      if (a) exp_q.push_back(lanes(p[23:16], p[15:8], p[7:0]));
      #160 link_clk <= 1'b1;
      #160 link_clk <= 1'b0;
    end
    link_de <= 1'b0;
    repeat (n * 16 + 80) @(posedge clk);
    check(exp_q.size(), 0);
    check(sync_detect_output, 1'b0);
  endtask

  // Sets both power pins and checks the clock, bus, control one and
  // sync detect enables once the synchroniser has passed them.
  task automatic pins(input logic f, d, input logic [3:0] exp);
    full_power_down_n <= f;
    output_driver_power_down_n <= d;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check({output_pixel_clock_oe, even_pixel_bus_oe,
           control_output_one_oe, sync_detect_output_oe}, exp);
    @(posedge clk);
  endtask

  // Each active capture holds the next pixel, and its partner in two-pixel
  // mode, or zero where the line has run out.
  always @(cap_count) begin
    if (cap_de === 1'b1) begin
      check(cap_late, 1'b0);
      want = exp_q.size() ? exp_q.pop_front() : 24'h00_0000;
      check(cap_even, want);
      want = (wide && exp_q.size()) ? exp_q.pop_front() : 24'h00_0000;
      check(cap_odd, want);
    end
  end

  initial begin
    rst_n = 1'b0;
    {full_power_down_n, output_driver_power_down_n} = 2'h3;
    {link_clk, link_de, link_hsync, link_vsync, link_ctl} = 6'h00;
    {link_red, link_green, link_blue} = 24'h00_0000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, edge_sel, wide} = 4'h2;
    void'($urandom(32'h7a48));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 8'h00, 32'h0000_0000, q, r);
    check(q, 32'h0000_0001);
    bus(1'b1, 8'h08, 32'h0000_0003, q, r);
    check(r, 2'h2);
    bus(1'b0, 8'h08, 32'h0000_0000, q, r);
    check({r, q[7:0]}, 10'h200);
    // Every edge and width setting; a one-pixel line comes first.
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, 8'h00, m, q, r);
      edge_sel <= m[0];
      wide <= m[1];
      bus(1'b0, 8'h00, 32'h0000_0000, q, r);
      check(q, m);
      for (int k = 0; k < 3; k++) send_line(k == 0 ? 1 : 2 + $urandom % 7);
    end
    pins(1'b1, 1'b0, 4'b0011);
    pins(1'b1, 1'b1, 4'b1111);
    pins(1'b0, 1'b1, 4'b0000);
    pins(1'b1, 1'b1, 4'b1111);
    send_line(5);
    print_verdict;
  end
endmodule
